// *** ssirc_control.sv ***
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module ssirc_control #(
    parameter int CLK_OUT_DIV_W = 3
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // register bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // supply monitor
    input wire logic POWER_ON_RESET,
    input wire logic LOW_SUPPLY_TRIP,
    input wire logic WARNING_TRIP,
    input wire logic STOP_MODE,
    output logic DETECTOR_ON,
    output logic DETECTOR_HIGH_TRIP,
    output logic WARNING_HIGH_TRIP,
    output logic LOW_VOLTAGE_RESET,
    output logic LOW_VOLTAGE_IRQ,
    output logic STOP2_ALLOWED,
    output logic OSC_STOP_ENABLE,
    // periodic interrupt
    input wire logic KHZ_TICK,
    input wire logic EXT_CLK_TICK,
    output logic PERIODIC_IRQ,
    output logic PERIODIC_STOP2_WAKE,
    // shared port pin
    input wire logic PORT_DIR,
    input wire logic PORT_DATA,
    output logic SHARED_PIN_OUT,
    output logic SHARED_PIN_OE,
    // interrupt pin
    input wire logic IRQ_PIN,
    output logic PIN_PULL_DOWN,
    output logic PIN_IRQ
);

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } ssirc_bus_t;

    typedef struct packed {
        ssirc_bus_t bus;
        logic [7:0] addr;
        logic hready;
        logic [31:0] hrdata;
        logic pin_edge;
        logic pin_func;
        logic pin_flag;
        logic pin_ie;
        logic pin_mode;
        logic pin_prev;
        logic det_en;
        logic det_stop;
        logic det_rst;
        logic det_ie;
        logic det_flag;
        logic det_vsel;
        logic warn_vsel;
        logic warn_flag;
        logic osc_stop;
        logic lv_hold;
        logic lv_cause;
        logic rst_por;
        logic rst_lv;
        logic per_clksel;
        logic per_ie;
        logic per_flag;
        logic [ssirc_pkg::PER_RATE_W-1:0] per_rate;
        logic clk_en;
        logic [CLK_OUT_DIV_W-1:0] clk_div;
        logic [CLK_OUT_DIV_W-1:0] div_cnt;
        logic clk_lvl;
        logic det_on;
        logic lv_irq;
        logic stop2_ok;
        logic per_irq;
        logic per_wake;
        logic pin_out;
        logic pin_oe;
        logic pull_down;
        logic pin_irq;
    } ssirc_state_t;

    ssirc_state_t st_q;
    ssirc_state_t st_d;
    logic per_tick;
    logic per_expire;
    logic pin_asserted;
    logic pin_event;
    logic [31:0] rd_word;
    logic [7:0] wr_byte;

    // the divider field must fit the control register beside the enable
    if (CLK_OUT_DIV_W < 1 || CLK_OUT_DIV_W > 7) begin : g_div_check
        $error("CLK_OUT_DIV_W must lie between 1 and 7");
    end

    ////////////////////////////////////////////////////////////////////////
    // periodic timer on the selected source; ticks are bus-clock enables
    assign per_tick = st_q.per_clksel ? EXT_CLK_TICK : KHZ_TICK;

    ssirc_periodic_timer u_timer (
        .clk(CLOCK),
        .rst(SYS_RST),
        .tick(per_tick),
        .rate(st_q.per_rate),
        .expire(per_expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt pin level in the selected polarity, and the event it makes
    assign pin_asserted = st_q.pin_edge ? IRQ_PIN : ~IRQ_PIN;
    // an edge is a fresh asserted level; level mode also counts the level
    assign pin_event = st_q.pin_func &&
        ((pin_asserted && !st_q.pin_prev) ||
         (st_q.pin_mode && pin_asserted));

    ////////////////////////////////////////////////////////////////////////
    // read view of the registers; unmapped words and reserved bits read 0
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (st_q.addr)
            ssirc_pkg::OFS_PIN_CTRL: begin
                rd_word[ssirc_pkg::PIN_EDGE_POS] = st_q.pin_edge;
                rd_word[ssirc_pkg::PIN_FUNC_POS] = st_q.pin_func;
                rd_word[ssirc_pkg::PIN_FLAG_POS] = st_q.pin_flag;
                rd_word[ssirc_pkg::PIN_IE_POS] = st_q.pin_ie;
                rd_word[ssirc_pkg::PIN_MODE_POS] = st_q.pin_mode;
            end
            ssirc_pkg::OFS_PWR_ONE: begin
                rd_word[ssirc_pkg::DET_EN_POS] = st_q.det_en;
                rd_word[ssirc_pkg::DET_STOP_POS] = st_q.det_stop;
                rd_word[ssirc_pkg::DET_RST_POS] = st_q.det_rst;
                rd_word[ssirc_pkg::DET_IE_POS] = st_q.det_ie;
                rd_word[ssirc_pkg::DET_FLAG_POS] = st_q.det_flag;
            end
            ssirc_pkg::OFS_PWR_TWO: begin
                rd_word[ssirc_pkg::DET_VSEL_POS] = st_q.det_vsel;
                rd_word[ssirc_pkg::WARN_VSEL_POS] = st_q.warn_vsel;
                rd_word[ssirc_pkg::WARN_FLAG_POS] = st_q.warn_flag;
                rd_word[ssirc_pkg::OSC_STOP_POS] = st_q.osc_stop;
            end
            ssirc_pkg::OFS_RST_STATUS: begin
                rd_word[ssirc_pkg::RST_POR_POS] = st_q.rst_por;
                rd_word[ssirc_pkg::RST_LV_POS] = st_q.rst_lv;
            end
            ssirc_pkg::OFS_PERIODIC: begin
                rd_word[ssirc_pkg::PER_FLAG_POS] = st_q.per_flag;
                rd_word[ssirc_pkg::PER_CLKSEL_POS] = st_q.per_clksel;
                rd_word[ssirc_pkg::PER_IE_POS] = st_q.per_ie;
                rd_word[ssirc_pkg::PER_RATE_POS +: ssirc_pkg::PER_RATE_W] =
                    st_q.per_rate;
            end
            ssirc_pkg::OFS_CLK_OUT: begin
                rd_word[ssirc_pkg::CLK_OUT_EN_POS] = st_q.clk_en;
                rd_word[ssirc_pkg::CLK_OUT_DIV_POS +: CLK_OUT_DIV_W] =
                    st_q.clk_div;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign wr_byte = HWDATA[7:0];

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        st_d = st_q;

        // bus: writes complete with no wait, reads take one wait cycle so
        // the returned word always reflects a write just before it
        if (st_q.bus == BUS_READ) begin
            st_d.hrdata = rd_word;
            st_d.hready = 1'b1;
            st_d.bus = BUS_IDLE;
        end else if (st_q.bus == BUS_WRITE) begin
            st_d.bus = BUS_IDLE;
        end
        if (st_q.hready && HREADY && HSEL && HTRANS[1]) begin
            st_d.addr = HADDR[7:0];
            if (HWRITE) begin
                st_d.bus = BUS_WRITE;
            end else begin
                st_d.bus = BUS_READ;
                st_d.hready = 1'b0;
            end
        end

        // hardware events; each flag set below outranks a clear in the
        // same cycle because the clear is applied first
        if (st_q.bus == BUS_WRITE) begin
            unique case (st_q.addr)
                ssirc_pkg::OFS_PIN_CTRL: begin
                    st_d.pin_edge = wr_byte[ssirc_pkg::PIN_EDGE_POS];
                    st_d.pin_func = wr_byte[ssirc_pkg::PIN_FUNC_POS];
                    st_d.pin_ie = wr_byte[ssirc_pkg::PIN_IE_POS];
                    st_d.pin_mode = wr_byte[ssirc_pkg::PIN_MODE_POS];
                    // a held level keeps the flag in level mode
                    if (wr_byte[ssirc_pkg::PIN_ACK_POS] &&
                        !(st_q.pin_mode && pin_asserted)) begin
                        st_d.pin_flag = 1'b0;
                    end
                end
                ssirc_pkg::OFS_PWR_ONE: begin
                    st_d.det_en = wr_byte[ssirc_pkg::DET_EN_POS];
                    st_d.det_stop = wr_byte[ssirc_pkg::DET_STOP_POS];
                    st_d.det_rst = wr_byte[ssirc_pkg::DET_RST_POS];
                    st_d.det_ie = wr_byte[ssirc_pkg::DET_IE_POS];
                    if (wr_byte[ssirc_pkg::DET_ACK_POS]) begin
                        st_d.det_flag = 1'b0;
                    end
                end
                ssirc_pkg::OFS_PWR_TWO: begin
                    st_d.det_vsel = wr_byte[ssirc_pkg::DET_VSEL_POS];
                    st_d.warn_vsel = wr_byte[ssirc_pkg::WARN_VSEL_POS];
                    st_d.osc_stop = wr_byte[ssirc_pkg::OSC_STOP_POS];
                end
                ssirc_pkg::OFS_PERIODIC: begin
                    st_d.per_clksel = wr_byte[ssirc_pkg::PER_CLKSEL_POS];
                    st_d.per_ie = wr_byte[ssirc_pkg::PER_IE_POS];
                    st_d.per_rate = wr_byte[ssirc_pkg::PER_RATE_POS +:
                        ssirc_pkg::PER_RATE_W];
                    if (wr_byte[ssirc_pkg::PER_ACK_POS]) begin
                        st_d.per_flag = 1'b0;
                    end
                end
                ssirc_pkg::OFS_CLK_OUT: begin
                    st_d.clk_en = wr_byte[ssirc_pkg::CLK_OUT_EN_POS];
                    st_d.clk_div = wr_byte[ssirc_pkg::CLK_OUT_DIV_POS +:
                        CLK_OUT_DIV_W];
                end
                default: ;
            endcase
        end

        // interrupt pin
        st_d.pin_prev = pin_asserted;
        if (pin_event) begin
            st_d.pin_flag = 1'b1;
        end
        st_d.pin_irq = st_d.pin_flag && st_d.pin_ie;
        // rising sensitivity turns the optional pull-up into a pull-down
        st_d.pull_down = st_d.pin_func && st_d.pin_edge;

        // low-voltage detector; in stop it stays on only if allowed
        st_d.det_on = st_d.det_en &&
            (!STOP_MODE || st_d.det_stop);
        st_d.stop2_ok = !(st_d.det_en && st_d.det_stop);
        st_d.warn_flag = WARNING_TRIP;
        if (st_q.det_on && st_q.det_en && st_q.det_ie && !st_q.det_rst &&
            LOW_SUPPLY_TRIP) begin
            st_d.det_flag = 1'b1;
        end
        st_d.lv_irq = st_d.det_flag && st_d.det_ie;
        // reset is held while the comparator still reports a low supply
        if (st_q.det_on && st_q.det_rst && LOW_SUPPLY_TRIP) begin
            st_d.lv_hold = 1'b1;
        end else if (!LOW_SUPPLY_TRIP) begin
            st_d.lv_hold = 1'b0;
        end
        // remember a low-voltage reset until the reset itself has run
        st_d.lv_cause = st_q.lv_cause || st_d.lv_hold;

        // periodic interrupt; wake from stop2 only on the internal clock
        if (per_expire) begin
            st_d.per_flag = 1'b1;
        end
        st_d.per_irq = st_d.per_flag && st_d.per_ie;
        st_d.per_wake = st_d.per_ie && !st_d.per_clksel &&
            (st_d.per_rate != 3'h0);

        // clock output: one level change every clk_div bus cycles, so the
        // output runs at the bus rate over twice the field value
        if (!st_q.clk_en || st_q.clk_div == '0) begin
            st_d.div_cnt = '0;
            st_d.clk_lvl = 1'b0;
        end else if (st_q.div_cnt >= st_q.clk_div - 1'b1) begin
            st_d.div_cnt = '0;
            st_d.clk_lvl = ~st_q.clk_lvl;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 1'b1;
        end
        // the enable overrides the port direction bit
        st_d.pin_oe = st_q.clk_en || PORT_DIR;
        st_d.pin_out = st_q.clk_en ? st_d.clk_lvl : PORT_DATA;

        // synchronous reset; cause bits are taken from the reset source
        if (SYS_RST) begin
            st_d = '0;
            st_d.bus = BUS_IDLE;
            st_d.hready = 1'b1;
            st_d.det_en = ssirc_pkg::DET_EN_RST;
            st_d.det_rst = ssirc_pkg::DET_RST_EN_RST;
            st_d.det_stop = ssirc_pkg::DET_STOP_RST;
            st_d.per_rate = ssirc_pkg::PER_RATE_RST;
            st_d.stop2_ok = !(ssirc_pkg::DET_EN_RST &&
                ssirc_pkg::DET_STOP_RST);
            st_d.det_on = ssirc_pkg::DET_EN_RST;
            st_d.pin_oe = PORT_DIR;
            st_d.pin_out = PORT_DATA;
            // power-up is held until the supply clears the trip level
            st_d.lv_hold = POWER_ON_RESET ||
                (st_q.lv_hold && LOW_SUPPLY_TRIP);
            st_d.lv_cause = POWER_ON_RESET || st_q.lv_cause;
            st_d.rst_por = POWER_ON_RESET ||
                (st_q.lv_cause && st_q.rst_por);
            st_d.rst_lv = POWER_ON_RESET ||
                st_q.lv_cause;
        end else if (st_q.lv_cause && !st_q.lv_hold) begin
            // cause is only needed across one reset
            st_d.lv_cause = st_d.lv_hold;
        end
    end

    always_ff @(posedge CLOCK) begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all but the constant HRESP taken from the state register
    assign HREADYOUT = st_q.hready;
    assign HRESP = 1'b0; // always OKAY
    assign HRDATA = st_q.hrdata;
    assign DETECTOR_ON = st_q.det_on;
    assign DETECTOR_HIGH_TRIP = st_q.det_vsel;
    assign WARNING_HIGH_TRIP = st_q.warn_vsel;
    assign LOW_VOLTAGE_RESET = st_q.lv_hold;
    assign LOW_VOLTAGE_IRQ = st_q.lv_irq;
    assign STOP2_ALLOWED = st_q.stop2_ok;
    assign OSC_STOP_ENABLE = st_q.osc_stop;
    assign PERIODIC_IRQ = st_q.per_irq;
    assign PERIODIC_STOP2_WAKE = st_q.per_wake;
    assign SHARED_PIN_OUT = st_q.pin_out;
    assign SHARED_PIN_OE = st_q.pin_oe;
    assign PIN_PULL_DOWN = st_q.pull_down;
    assign PIN_IRQ = st_q.pin_irq;

endmodule
`default_nettype wire

// *** ssirc_control_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module ssirc_mon (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic LOW_SUPPLY_TRIP,
    input wire logic STOP_MODE,
    input wire logic DETECTOR_ON,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic STOP2_ALLOWED,
    input wire logic PORT_DIR,
    input wire logic SHARED_PIN_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////
    // a taken read stalls one cycle, then the data stands
    sequence rd_take;
        HSEL && HTRANS[1] && HREADY && HREADYOUT && !HWRITE;
    endsequence
    sequence rd_pin;
        rd_take ##0 (HADDR[7:0] == 8'h00);
    endsequence
    sequence rd_answer;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    hresp_okay_a: assert property (HRESP == 1'b0)
        else $error("bad response");
    rd_wait_a: assert property (rd_take |=> rd_answer)
        else $error("read stall wrong");
    wr_nowait_a: assert property (HSEL && HTRANS[1] && HREADY
        && HREADYOUT && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    rd_pin_bits_a: assert property (
        rd_pin |=> ##1 (HRDATA[7:6] == 2'h0 && !HRDATA[2]))
        else $error("pin reg unused bits set");
    ////////////////////////////////////////////////////////////////////////
    // past reset guards skip the cycle that still shows reset values
    stop_off_a: assert property (
        STOP2_ALLOWED && $past(STOP2_ALLOWED) && $past(STOP_MODE)
        && !$past(SYS_RST) |-> !DETECTOR_ON)
        else $error("detector on in stop");
    stop2_det_a: assert property (
        !STOP2_ALLOWED && !$past(STOP2_ALLOWED) |-> DETECTOR_ON)
        else $error("stop2 refused while detector off");
    pin_oe_a: assert property ($past(PORT_DIR) |-> SHARED_PIN_OE)
        else $error("shared pin not driven");
    lvr_cause_a: assert property (
        $rose(LOW_VOLTAGE_RESET) && !$past(SYS_RST)
        |-> $past(LOW_SUPPLY_TRIP))
        else $error("reset hold without low supply");
    lvr_release_a: assert property (
        LOW_VOLTAGE_RESET && !LOW_SUPPLY_TRIP |=> !LOW_VOLTAGE_RESET)
        else $error("reset hold kept with good supply");
endmodule
bind ssirc_control ssirc_mon u_ssirc_mon (.CLOCK, .SYS_RST, .HSEL,
    .HADDR, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
    .LOW_SUPPLY_TRIP, .STOP_MODE, .DETECTOR_ON, .LOW_VOLTAGE_RESET,
    .STOP2_ALLOWED, .PORT_DIR, .SHARED_PIN_OE);
`default_nettype wire

// *** ssirc_control_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ssirc_control_tb_top;
    logic clk, rst, hsel, hwrite, por, trip, warn, stop, pdir, pdat, lvl;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic hrdy, hresp, don, dhi, whi, lvr, lvq, s2ok, osc, pq, pwk;
    logic sout, soe, pin, pdn, pnq, khz, ext, x;
    int bad_count, samples_checked, n;
    ssirc_control u_ssirc_control (.CLOCK(clk), .SYS_RST(rst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy),
        .HRESP(hresp), .HRDATA(hrdata), .POWER_ON_RESET(por),
        .LOW_SUPPLY_TRIP(trip), .WARNING_TRIP(warn), .STOP_MODE(stop),
        .DETECTOR_ON(don), .DETECTOR_HIGH_TRIP(dhi),
        .WARNING_HIGH_TRIP(whi), .LOW_VOLTAGE_RESET(lvr),
        .LOW_VOLTAGE_IRQ(lvq), .STOP2_ALLOWED(s2ok), .OSC_STOP_ENABLE(osc),
        .KHZ_TICK(khz), .EXT_CLK_TICK(ext), .PERIODIC_IRQ(pq),
        .PERIODIC_STOP2_WAKE(pwk), .PORT_DIR(pdir), .PORT_DATA(pdat),
        .SHARED_PIN_OUT(sout), .SHARED_PIN_OE(soe), .IRQ_PIN(pin),
        .PIN_PULL_DOWN(pdn), .PIN_IRQ(pnq));
    ssirc_pin_source u_ssirc_pin_source (.clk(clk), .rst(rst),
        .level(lvl), .irq_pin(pin), .khz_tick(khz), .ext_tick(ext));
    ////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, v);
        end
    endtask
    // bounded wait for hready sampled high at a rising edge
    task wt;
        int k;
        k = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            k++;
            // a slave that never answers is a failure, not a silent pass
            if (k > 40) begin
                bad_count++;
                results();
            end
            @(posedge clk);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wt();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wt();
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e, input string s);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wt();
        htrans <= 2'h0;
        wt();
        chk(s, {24'h0, e}, hrdata);
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task wirq;
        for (n = 0; pq !== 1'b1; n++) begin
            if (n > 300) begin
                bad_count++;
                results();
            end
            @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk("det_on", 1, don);
        rdc(8'h04, 8'h05, "pwr_one");
        rdc(8'h0C, 8'h82, "rst_status");
        rdc(8'h18, 8'h00, "unmapped");
        rdc(8'h00, 8'h00, "pin_ctrl");
        $display("reset test done");
    endtask
    task t_pin;
        wr(8'h00, 8'h12);
        lvl <= 1'b0;
        cyc(4);
        chk("pin_irq", 1, pnq);
        rdc(8'h00, 8'h1A, "pin_flag");
        lvl <= 1'b1;
        wr(8'h00, 8'h16);
        rdc(8'h00, 8'h12, "pin_ack");
        wr(8'h00, 8'h13);
        lvl <= 1'b0;
        cyc(4);
        wr(8'h00, 8'h17);
        rdc(8'h00, 8'h1B, "level_hold");
        lvl <= 1'b1;
        cyc(4);
        wr(8'h00, 8'h17);
        rdc(8'h00, 8'h13, "level_ack");
        wr(8'h00, 8'h32);
        cyc(2);
        chk("pull_down", 1, pdn);
        $display("pin test done");
    endtask
    task t_volt;
        wr(8'h08, 8'h0B);
        warn <= 1'b1;
        wr(8'h04, 8'h09);
        trip <= 1'b1;
        cyc(3);
        chk("trip_sel", 3'h7, {dhi, whi, osc});
        chk("lv_irq", 2'h2, {lvq, lvr});
        rdc(8'h08, 8'h0F, "warn_flag");
        trip <= 1'b0;
        wr(8'h04, 8'h25);
        trip <= 1'b1;
        cyc(3);
        chk("lv_reset", 1, lvr);
        trip <= 1'b0;
        cyc(3);
        chk("lv_release", 0, lvr);
        wr(8'h04, 8'h03);
        stop <= 1'b1;
        cyc(3);
        chk("stop2_on", 2'h1, {s2ok, don});
        wr(8'h04, 8'h01);
        cyc(3);
        chk("stop_off", 2'h2, {s2ok, don});
        stop <= 1'b0;
        wr(8'h04, 8'h00);
        cyc(3);
        chk("det_off", 0, don);
        $display("voltage test done");
    endtask
    task t_per;
        wr(8'h10, 8'h11);
        // the wake output is registered on the same edge the write lands; wait one edge to sample it
        cyc(1);
        chk("wake_khz", 1, pwk);
        wirq();
        chk("per_early", 1, n >= 24);
        rdc(8'h10, 8'h91, "per_flag");
        wr(8'h10, 8'h51);
        rdc(8'h10, 8'h11, "per_ack");
        wr(8'h10, 8'h31);
        cyc(1);
        chk("wake_ext", 0, pwk);
        wirq();
        wr(8'h10, 8'h50);
        cyc(150);
        chk("rate_zero", 0, pq);
        wr(8'h10, 8'h01);
        cyc(100);
        chk("per_mask", 0, pq);
        rdc(8'h10, 8'h81, "masked_flag");
        $display("periodic test done");
    endtask
    task t_clk;
        wr(8'h14, 8'h03);
        cyc(3);
        x = sout;
        cyc(1);
        chk("clk_toggle", {soe, ~x}, {soe, sout});
        chk("forced_out", 1, soe);
        wr(8'h14, 8'h01);
        cyc(3);
        chk("div_zero", 0, sout);
        // with the clock output off the port direction and data own the pin
        wr(8'h14, 8'h00);
        pdir <= 1'b1;
        pdat <= 1'b1;
        cyc(3);
        chk("port_path", 2'h3, {soe, sout});
        $display("clock out test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // power-on reset held for twelve cycles, bus idle throughout
    initial begin
        {hsel, hwrite, trip, warn, stop, pdir, pdat} = 7'h40;
        {rst, por, lvl, haddr, hwdata} = '1;
        htrans = 2'h0;
        bad_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        cyc(2);
        t_reset();
        t_pin();
        t_volt();
        t_per();
        t_clk();
        results();
    end
endmodule
`default_nettype wire

// *** ssirc_periodic_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module ssirc_periodic_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [ssirc_pkg::PER_RATE_W-1:0] rate,
    output logic expire
);

    typedef struct packed {
        logic [10:0] cnt;
        logic expire;
    } ssirc_timer_state_t;

    ssirc_timer_state_t st_q;
    ssirc_timer_state_t st_d;
    logic [10:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // period length from the rate code; code zero never reaches the count
    always_comb begin
        unique case (rate)
            3'h1: limit = ssirc_pkg::PER_TICKS_1;
            3'h2: limit = ssirc_pkg::PER_TICKS_2;
            3'h3: limit = ssirc_pkg::PER_TICKS_3;
            3'h4: limit = ssirc_pkg::PER_TICKS_4;
            3'h5: limit = ssirc_pkg::PER_TICKS_5;
            3'h6: limit = ssirc_pkg::PER_TICKS_6;
            3'h7: limit = ssirc_pkg::PER_TICKS_7;
            default: limit = ssirc_pkg::PER_TICKS_7;
        endcase
    end

    // count source ticks; rate zero clears the count to zero and stops it
    always_comb begin
        st_d = st_q;
        st_d.expire = 1'b0;
        if (rate == 3'h0) begin
            st_d.cnt = 11'h000;
        end else if (tick) begin
            if (st_q.cnt >= limit - 11'h001) begin
                st_d.cnt = 11'h000;
                st_d.expire = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 11'h001;
            end
        end
        if (rst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign expire = st_q.expire;

endmodule
`default_nettype wire

// *** ssirc_pin_source.sv ***
`timescale 1ns/10ps
`default_nettype none
module ssirc_pin_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic irq_pin,
    output logic khz_tick,
    output logic ext_tick
);
    logic [3:0] cnt_q;
    // pin idles high on its pull-up; level changes land one edge later
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 4'h0;
            irq_pin <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            irq_pin <= level;
        end
    end
    // two tick rates so a wrong source choice shows in timing
    assign khz_tick = cnt_q[1:0] == 2'h3;
    assign ext_tick = cnt_q[2:0] == 3'h5;
endmodule
`default_nettype wire

// *** ssirc_pkg.sv ***
`default_nettype none
package ssirc_pkg;

    // register byte addresses on the word bus
    localparam logic [7:0] OFS_PIN_CTRL = 8'h00;
    localparam logic [7:0] OFS_PWR_ONE = 8'h04;
    localparam logic [7:0] OFS_PWR_TWO = 8'h08;
    localparam logic [7:0] OFS_RST_STATUS = 8'h0C;
    localparam logic [7:0] OFS_PERIODIC = 8'h10;
    localparam logic [7:0] OFS_CLK_OUT = 8'h14;

    // irq_pin_status_control fields
    localparam int PIN_EDGE_POS = 5;
    localparam int PIN_FUNC_POS = 4;
    localparam int PIN_FLAG_POS = 3;
    localparam int PIN_ACK_POS = 2;
    localparam int PIN_IE_POS = 1;
    localparam int PIN_MODE_POS = 0;

    // power_control_one fields
    localparam int DET_EN_POS = 0;
    localparam int DET_STOP_POS = 1;
    localparam int DET_RST_POS = 2;
    localparam int DET_IE_POS = 3;
    localparam int DET_FLAG_POS = 4;
    localparam int DET_ACK_POS = 5;

    // power_control_two fields
    localparam int DET_VSEL_POS = 0;
    localparam int WARN_VSEL_POS = 1;
    localparam int WARN_FLAG_POS = 2;
    localparam int OSC_STOP_POS = 3;

    // reset_status_register fields
    localparam int RST_POR_POS = 7;
    localparam int RST_LV_POS = 1;

    // periodic_status_control fields
    localparam int PER_FLAG_POS = 7;
    localparam int PER_ACK_POS = 6;
    localparam int PER_CLKSEL_POS = 5;
    localparam int PER_IE_POS = 4;
    localparam int PER_RATE_POS = 0;
    localparam int PER_RATE_W = 3;

    // clock-output control fields
    localparam int CLK_OUT_EN_POS = 0;
    localparam int CLK_OUT_DIV_POS = 1;

    // reset values of the control bits
    localparam logic DET_EN_RST = 1'b1;
    localparam logic DET_RST_EN_RST = 1'b1;
    localparam logic DET_STOP_RST = 1'b0;
    localparam logic [PER_RATE_W-1:0] PER_RATE_RST = 3'h0;

    // periodic timer length in source ticks, per nonzero rate code
    localparam logic [10:0] PER_TICKS_1 = 11'h008;
    localparam logic [10:0] PER_TICKS_2 = 11'h020;
    localparam logic [10:0] PER_TICKS_3 = 11'h040;
    localparam logic [10:0] PER_TICKS_4 = 11'h080;
    localparam logic [10:0] PER_TICKS_5 = 11'h100;
    localparam logic [10:0] PER_TICKS_6 = 11'h200;
    localparam logic [10:0] PER_TICKS_7 = 11'h400;

endpackage
`default_nettype wire
